// >>> rtl/cef_map.vh
`ifndef CEF_MAP_VH
`define CEF_MAP_VH
`define CEF_FLAG_BITS      4'd6
`define CEF_DELIM_BITS     4'd8
`define CEF_IFS_BITS       2'd3
`define CEF_IDLE_BITS      4'd11
`define CEF_STUFF_LIMIT    3'd6
`define CEF_BOFF_GROUPS    8'd128
`define CEF_WARN_LEVEL     9'd96
`define CEF_PASSIVE_LEVEL  9'd127
`define CEF_BOFF_LEVEL     9'd255
`define CEF_ERR_INC_TX     9'd8
`define CEF_ERR_INC_RX     9'd1
`define CEF_CNT_RESET      8'h00
`endif

// >>> rtl/cef_fault_state.v
`timescale 1ns/100ps
`default_nettype none
`include "cef_map.vh"
module cef_fault_state #(
	parameter CNT_W = 8
) (
	input  wire             clk_i,
	input  wire             nrst_i,
	input  wire             enable_i,
	input  wire             wake_i,
	input  wire             bit_tick_i,
	input  wire             rx_pin_i,
	input  wire             tx_bit_i,
	input  wire             transmitting_i,
	input  wire             arbitration_i,
	input  wire             ack_slot_i,
	input  wire             ack_delim_i,
	input  wire             stuffed_field_i,
	input  wire             fixed_bit_i,
	input  wire             fixed_level_i,
	input  wire             eof_last_i,
	input  wire             eof_done_i,
	input  wire             remote_i,
	input  wire             rtr_slot_i,
	input  wire             data_field_i,
	input  wire             crc_check_i,
	input  wire             crc_zero_i,
	input  wire             frame_ok_i,
	output reg              tx_o,
	output reg              drive_en_o,
	output reg              tx_ready_o,
	output reg              suppress_data_o,
	output reg              err_flag_o,
	output reg              ovl_flag_o,
	output reg  [4:0]       err_kind_o,
	output reg  [CNT_W-1:0] rec_o,
	output reg  [CNT_W-1:0] tec_o,
	output reg  [4:0]       state_o
);

////////////////////////////////////////////////////////////////////////////////
// Fault states, one-hot
// Warning is a sub-state of active and behaves like it on the bus
localparam [4:0] ST_SYNC = 5'h01;
localparam [4:0] ST_ACT  = 5'h02;
localparam [4:0] ST_WARN = 5'h04;
localparam [4:0] ST_PASS = 5'h08;
localparam [4:0] ST_BOFF = 5'h10;

// Frame phases for flag generation
// IFS is the three-bit intermission before a new frame may be released
localparam [3:0] PH_IDLE = 4'h1;
localparam [3:0] PH_FLAG = 4'h2;
localparam [3:0] PH_DLM  = 4'h4;
localparam [3:0] PH_IFS  = 4'h8;

////////////////////////////////////////////////////////////////////////////////
// Bus pin synchroniser
// The bus level is asynchronous to clk_i; nothing reads rx_s1 but rx_s2
reg rx_s1;
reg rx_s2;
always @(posedge clk_i or negedge nrst_i) begin
	if (!nrst_i) begin
		rx_s1 <= 1'b1;
		rx_s2 <= 1'b1;
	end else begin
		rx_s1 <= rx_pin_i;
		rx_s2 <= rx_s1;
	end
end
wire rx = rx_s2;

////////////////////////////////////////////////////////////////////////////////
// Error detection, evaluated on each bit tick
// Errors are only counted outside a running flag, so one disturbance
// costs one increment however many bits of it we see
reg       prev_rx;
reg [2:0] same_cnt;
reg       crc_pend;
reg [3:0] phase;
reg [3:0] ph_cnt;
reg       flag_is_ovl;
reg       flag_active;

// Dominant seen on the bus while we send a passive flag is not our fault
wire bit_err = transmitting_i && (tx_bit_i != rx) &&
	!(rx == 1'b0 && tx_bit_i == 1'b1 &&
	  (arbitration_i || ack_slot_i || (phase == PH_FLAG && !flag_active)));
wire stuff_err = stuffed_field_i && (rx == prev_rx) &&
	(same_cnt == `CEF_STUFF_LIMIT - 3'd1);
wire form_err  = fixed_bit_i && (rx != fixed_level_i) && !(eof_last_i && rx == 1'b0);
wire crc_err   = crc_check_i && !crc_zero_i;
wire ack_err   = transmitting_i && ack_slot_i && rx;
wire imm_err   = bit_err || stuff_err || form_err || ack_err;
// Stuff counting restarts outside stuffed fields and on every level change
// A dominant final EOF bit from a receiver means another node is overloaded
wire ovl_seen  = (eof_last_i && !rx) || (phase == PH_IFS && !rx);

always @(posedge clk_i or negedge nrst_i) begin
	if (!nrst_i) begin
		prev_rx  <= 1'b1;
		same_cnt <= 3'd0;
	end else if (bit_tick_i) begin
		prev_rx <= rx;
		if (!stuffed_field_i || rx != prev_rx)
			same_cnt <= 3'd1;
		else if (same_cnt != `CEF_STUFF_LIMIT)
			same_cnt <= same_cnt + 3'd1;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Fault-confinement state and counters
reg [4:0]       state;
reg [CNT_W-1:0] rec;
reg [CNT_W-1:0] tec;
reg [3:0]       idle_cnt;
reg [7:0]       grp_cnt;

// Sync and bus off take no part in traffic and count no errors
wire bus_on = (state != ST_SYNC) && (state != ST_BOFF);
wire err_now = bus_on && bit_tick_i && (phase != PH_FLAG) && (imm_err || crc_err);

// Saturating sums one bit wider so overflow past 255 is visible
// The 14- and 8-dominant-bit penalties are not modelled: every error
// costs +8 on the transmit side or +1 on the receive side until rec reaches 128
wire [CNT_W:0] tec_up = {1'b0, tec} + `CEF_ERR_INC_TX;
wire [CNT_W:0] rec_up = {1'b0, rec} + `CEF_ERR_INC_RX;
reg  [CNT_W:0] next_tec;
reg  [CNT_W:0] next_rec;
always @* begin
	next_tec = {1'b0, tec};
	next_rec = {1'b0, rec};
	if (err_now) begin
		if (transmitting_i)
			next_tec = tec_up;
		else if (!rec[CNT_W-1])
			next_rec = rec_up;
	end else if (bus_on && bit_tick_i && frame_ok_i) begin
		if (tec != `CEF_CNT_RESET)
			next_tec = {1'b0, tec} - 9'd1;
		if (rec != `CEF_CNT_RESET)
			next_rec = {1'b0, rec} - 9'd1;
	end
end

always @(posedge clk_i or negedge nrst_i) begin
	if (!nrst_i) begin
		state    <= ST_SYNC;
		rec      <= `CEF_CNT_RESET;
		tec      <= `CEF_CNT_RESET;
		idle_cnt <= 4'd0;
		grp_cnt  <= 8'd0;
	end else if (!enable_i || wake_i) begin
		// Counters survive a disable or wake; only the idle hunt restarts
		state    <= ST_SYNC;
		idle_cnt <= 4'd0;
		grp_cnt  <= 8'd0;
	end else begin
		if (bus_on) begin
			tec <= (next_tec > `CEF_BOFF_LEVEL) ? {CNT_W{1'b1}} : next_tec[CNT_W-1:0];
			rec <= next_rec[CNT_W-1:0];
		end
		case (state)
		ST_SYNC: begin
			if (bit_tick_i) begin
				idle_cnt <= rx ? idle_cnt + 4'd1 : 4'd0;
				if (rx && idle_cnt == `CEF_IDLE_BITS - 4'd1)
					state <= ST_ACT;
			end
		end
		ST_ACT, ST_WARN, ST_PASS: begin
			if (next_tec > `CEF_BOFF_LEVEL) begin
				state    <= ST_BOFF;
				idle_cnt <= 4'd0;
				grp_cnt  <= 8'd0;
			end else if (next_tec > `CEF_PASSIVE_LEVEL || next_rec > `CEF_PASSIVE_LEVEL)
				state <= ST_PASS;
			else if (next_tec >= `CEF_WARN_LEVEL || next_rec >= `CEF_WARN_LEVEL)
				state <= ST_WARN;
			else
				state <= ST_ACT;
		end
		// Groups of eleven recessive bits; any dominant bit restarts the group
		ST_BOFF: begin
			if (bit_tick_i) begin
				if (!rx)
					idle_cnt <= 4'd0;
				else if (idle_cnt == `CEF_IDLE_BITS - 4'd1) begin
					idle_cnt <= 4'd0;
					grp_cnt  <= grp_cnt + 8'd1;
					if (grp_cnt == `CEF_BOFF_GROUPS - 8'd1) begin
						state <= ST_ACT;
						tec   <= `CEF_CNT_RESET;
						rec   <= `CEF_CNT_RESET;
					end
				end else
					idle_cnt <= idle_cnt + 4'd1;
			end
		end
		default: state <= ST_SYNC;
		endcase
	end
end

////////////////////////////////////////////////////////////////////////////////
// Error and overload frame sequencer
// Active flags are decided by the state on the tick the flag starts, before the counters moved for all but
// CRC errors, so any other error that tips the node into passive still goes out dominant.
// Overload flags only answer a dominant bit seen in the last EOF bit or the intermission;
// nothing inside this block can ask for one on its own.
wire pass_now = (state == ST_PASS);
wire start_flag = err_now && !crc_err || (crc_pend && bit_tick_i && ack_delim_i);
reg  [3:0] next_phase;
always @* begin
	next_phase = phase;
	case (phase)
	PH_IDLE: begin
		if (start_flag || (bus_on && bit_tick_i && ovl_seen))
			next_phase = PH_FLAG;
	end
	PH_FLAG: begin
		if (bit_tick_i && ph_cnt == `CEF_FLAG_BITS - 4'd1)
			next_phase = PH_DLM;
	end
	PH_DLM: begin
		// Only recessive bits count, so superimposed flags stretch the delimiter
		if (bit_tick_i && ph_cnt == `CEF_DELIM_BITS - 4'd1 && rx)
			next_phase = PH_IFS;
	end
	PH_IFS: begin
		if (bit_tick_i && ovl_seen)
			next_phase = PH_FLAG;
		else if (bit_tick_i && ph_cnt == {2'b00, `CEF_IFS_BITS} - 4'd1)
			next_phase = PH_IDLE;
	end
	default: next_phase = PH_IDLE;
	endcase
end

always @(posedge clk_i or negedge nrst_i) begin
	if (!nrst_i) begin
		phase       <= PH_IDLE;
		ph_cnt      <= 4'd0;
		crc_pend    <= 1'b0;
		flag_is_ovl <= 1'b0;
		flag_active <= 1'b0;
	end else if (!bus_on) begin
		// A pending CRC flag dies with the bus connection
		phase    <= PH_IDLE;
		ph_cnt   <= 4'd0;
		crc_pend <= 1'b0;
	end else begin
		// CRC error waits for ack delimiter; earlier flag cancels the wait
		if (crc_err && bit_tick_i && phase == PH_IDLE && !imm_err)
			crc_pend <= 1'b1;
		else if (phase != PH_IDLE || (bit_tick_i && ack_delim_i))
			crc_pend <= 1'b0;
		if (phase == PH_IDLE && next_phase == PH_FLAG) begin
			flag_is_ovl <= !start_flag;
			flag_active <= !pass_now || !start_flag;
		end else if (phase == PH_IFS && next_phase == PH_FLAG) begin
			flag_is_ovl <= 1'b1;
			flag_active <= 1'b1;
		end
		if (next_phase != phase)
			ph_cnt <= 4'd0;
		else if (bit_tick_i && phase == PH_DLM && !rx)
			ph_cnt <= 4'd0;
		else if (bit_tick_i)
			ph_cnt <= ph_cnt + 4'd1;
		phase <= next_phase;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Registered outputs
always @(posedge clk_i or negedge nrst_i) begin
	if (!nrst_i) begin
		tx_o            <= 1'b1;
		drive_en_o      <= 1'b0;
		tx_ready_o      <= 1'b0;
		suppress_data_o <= 1'b0;
		err_flag_o      <= 1'b0;
		ovl_flag_o      <= 1'b0;
		err_kind_o      <= 5'h00;
		rec_o           <= `CEF_CNT_RESET;
		tec_o           <= `CEF_CNT_RESET;
		state_o         <= ST_SYNC;
	end else begin
		// Sync and bus off release the driver, so the wire reads recessive
		drive_en_o <= bus_on;
		if (phase == PH_FLAG)
			tx_o <= !flag_active;
		else if (phase == PH_DLM)
			tx_o <= 1'b1;
		else if (rtr_slot_i && transmitting_i)
			tx_o <= remote_i ? 1'b1 : tx_bit_i;
		else
			tx_o <= transmitting_i ? tx_bit_i : 1'b1;
		// Frames are released only after the intermission has run out
		tx_ready_o      <= bus_on && phase == PH_IDLE && eof_done_i;
		suppress_data_o <= remote_i && data_field_i;
		err_flag_o      <= phase == PH_FLAG && !flag_is_ovl;
		ovl_flag_o      <= phase == PH_FLAG && flag_is_ovl;
		// One-cycle pulse per bit so a checker can count individual errors
		err_kind_o      <= bit_tick_i && bus_on ?
			{bit_err, stuff_err, form_err, crc_err, ack_err} : 5'h00;
		rec_o   <= rec;
		tec_o   <= tec;
		state_o <= state;
	end
end

endmodule // cef_fault_state
`default_nettype wire

// >>> sim/cef_bus_node.sv
`timescale 1ns/100ps
`default_nettype none
// Far-side node on the shared wire; CAN bus is wired-AND with recessive high
module cef_bus_node (
	input  wire logic dut_tx_i,
	input  wire logic dut_en_i,
	input  wire logic node_dom_i,
	output wire logic bus_o
);
	// Released drivers read back recessive, as the bus idles there
	assign bus_o = (dut_en_i ? dut_tx_i : 1'b1) & ~node_dom_i;
endmodule // cef_bus_node
`default_nettype wire

// >>> sim/cef_fault_state_props.sv
`timescale 1ns/100ps
`default_nettype none
module cef_fault_state_props #(
	parameter CNT_W = 8
) (
	input wire logic             clk_i,
	input wire logic             nrst_i,
	input wire logic             enable_i,
	input wire logic             bit_tick_i,
	input wire logic             rx_pin_i,
	input wire logic             tx_o,
	input wire logic             drive_en_o,
	input wire logic             err_flag_o,
	input wire logic [4:0]       err_kind_o,
	input wire logic [CNT_W-1:0] rec_o,
	input wire logic [CNT_W-1:0] tec_o,
	input wire logic [4:0]       state_o
);
default clocking @(posedge clk_i); endclocking
default disable iff (!nrst_i);
////////////////////////////////////////////////////////////////
// Recessive run as the design sees it, two flops behind the pin
logic [1:0] rxd;
logic [3:0] run;
always @(posedge clk_i or negedge nrst_i) begin
	if (!nrst_i) begin
		rxd <= 2'h3;
		run <= 4'h0;
	end else begin
		rxd <= {rxd[0], rx_pin_i};
		if (bit_tick_i)
			run <= !rxd[1] ? 4'h0 : (run == 4'hF ? run : run + 4'h1);
	end
end
sequence s_left_sync;
	$past(state_o[0]) ##0 state_o[1];
endsequence
sequence s_flag_soon;
	##[0:4] err_flag_o;
endsequence
////////////////////////////////////////////////////////////////
a_sync_wait: assert property (s_left_sync |-> run >= 4'd11)
	else $error("left sync before eleven recessive bits");
a_flag_next_bit: assert property ((|{err_kind_o[4:2], err_kind_o[0]}) && tec_o < 8'hF0 |-> s_flag_soon)
	else $error("error flag did not start");
a_tec_step: assert property ($changed(tec_o) |->
	tec_o - $past(tec_o) == 8'd8 || $past(tec_o) - tec_o == 8'd1 || tec_o == 8'h00 || tec_o == 8'hFF)
	else $error("transmit counter bad step");
a_rec_step: assert property ($changed(rec_o) |->
	rec_o - $past(rec_o) == 8'd1 || $past(rec_o) - rec_o == 8'd1 || rec_o == 8'h00)
	else $error("receive counter bad step");
a_rec_hold: assert property (rec_o[7] |=> rec_o <= $past(rec_o))
	else $error("receive counter grew past bit 7");
a_warn_exit: assert property ((rec_o < 8'd96 && tec_o < 8'd96) [*4] |-> !state_o[2])
	else $error("warning held with low counters");
a_passive_enter: assert property ((enable_i && (rec_o[7] || tec_o[7])) [*4] |-> !(state_o[1] || state_o[2]))
	else $error("active with counter above 127");
a_passive_exit: assert property ((!rec_o[7] && !tec_o[7]) [*4] |-> !state_o[3])
	else $error("passive held with counters below 128");
a_boff_quiet: assert property ($rose(state_o[4]) |-> !drive_en_o [*8])
	else $error("drivers on while bus off");
a_sync_quiet: assert property ($rose(state_o[0]) |-> !drive_en_o [*8])
	else $error("drivers on while synchronizing");
endmodule // cef_fault_state_props
bind cef_fault_state cef_fault_state_props #(.CNT_W(CNT_W)) props_u (.clk_i(clk_i), .nrst_i(nrst_i),
	.enable_i(enable_i), .bit_tick_i(bit_tick_i), .rx_pin_i(rx_pin_i), .tx_o(tx_o), .drive_en_o(drive_en_o),
	.err_flag_o(err_flag_o), .err_kind_o(err_kind_o), .rec_o(rec_o), .tec_o(tec_o), .state_o(state_o));
`default_nettype wire

// >>> sim/cef_fault_state_test.sv
`timescale 1ns/100ps
`default_nettype none
module cef_fault_state_test;
typedef struct packed {logic [9:0] in; logic [2:0] n; logic [6:0] ev; logic [7:0] t; logic [7:0] r;} cef_row_t;
// in: arb tr txb fx fl ak eof dom stf ok
cef_row_t rows [7] = '{'{10'h040, 3'd1, 7'h44, 8'd0, 8'd1}, '{10'h002, 3'd6, 7'h48, 8'd0, 8'd2},
	'{10'h190, 3'd1, 7'h41, 8'd8, 8'd2}, '{10'h184, 3'd1, 7'h50, 8'd16, 8'd2},
	'{10'h384, 3'd1, 7'h00, 8'd16, 8'd2}, '{10'h001, 3'd1, 7'h00, 8'd15, 8'd1},
	'{10'h06C, 3'd1, 7'h20, 8'd15, 8'd1}};
cef_row_t   r;
logic       clk_i = 1'b0, nrst_i = 1'b0, bit_tick_i = 1'b0, enable_i = 1'b1, wake_i = 1'b0, clr = 1'b0;
logic       remote_i = 1'b0, data_field_i = 1'b0, crc_check_i = 1'b0, ack_delim_i = 1'b0, eof_done_i = 1'b1;
logic [9:0] in = 10'h000;
logic [6:0] seen = 7'h00;
logic [1:0] ph = 2'd0;
wire logic  rx_pin_i, tx_o, drive_en_o, tx_ready_o, suppress_data_o, err_flag_o, ovl_flag_o;
wire logic [4:0] err_kind_o, state_o;
wire logic [7:0] rec_o, tec_o;
int         mismatches = 0, tests_run = 0, k;
cef_fault_state dut_u (.clk_i(clk_i), .nrst_i(nrst_i), .enable_i(enable_i), .wake_i(wake_i),
	.bit_tick_i(bit_tick_i), .rx_pin_i(rx_pin_i), .tx_bit_i(in[7]), .transmitting_i(in[8]),
	.arbitration_i(in[9]), .ack_slot_i(in[4]), .ack_delim_i(ack_delim_i), .stuffed_field_i(in[1]),
	.fixed_bit_i(in[6]), .fixed_level_i(in[5]), .eof_last_i(in[3]), .eof_done_i(eof_done_i), .remote_i(remote_i),
	.rtr_slot_i(1'b0), .data_field_i(data_field_i), .crc_check_i(crc_check_i), .crc_zero_i(1'b0),
	.frame_ok_i(in[0]), .tx_o(tx_o), .drive_en_o(drive_en_o), .tx_ready_o(tx_ready_o),
	.suppress_data_o(suppress_data_o), .err_flag_o(err_flag_o), .ovl_flag_o(ovl_flag_o),
	.err_kind_o(err_kind_o), .rec_o(rec_o), .tec_o(tec_o), .state_o(state_o));
cef_bus_node node_u (.dut_tx_i(tx_o), .dut_en_i(drive_en_o), .node_dom_i(in[2]), .bus_o(rx_pin_i));
////////////////////////////////////////////////////////////////
always #10 clk_i = ~clk_i;
always @(posedge clk_i) begin
	ph <= ph + 2'd1;
	bit_tick_i <= (ph == 2'd3);
	// Dominant own flag is caught by tx_o low while the flag runs
	seen <= clr ? 7'h00 : seen | {err_flag_o & ~tx_o, ovl_flag_o, err_kind_o};
end
task automatic chk(input logic [23:0] got, input logic [23:0] exp);
	tests_run++;
	if (got !== exp) begin
		mismatches++;
		$display("BAD t=%0t seen=%h exp=%h", $time, got, exp);
	end
endtask
task automatic close_out(input logic hung);
	if (hung) mismatches++;
	if (mismatches == 0 && tests_run > 0) $display("STATUS OK");
	else $display("STATUS NOT OK");
	$finish;
endtask
task automatic tk(input int n);
	int j;
	repeat (n) begin
		j = 0;
		@(posedge clk_i);
		while (bit_tick_i !== 1'b1 && j < 8) begin
			@(posedge clk_i);
			j++;
		end
		if (j == 8) close_out(1'b1);
	end
endtask
task automatic settle;
	repeat (3) @(posedge clk_i);
endtask
task automatic ready;
	int i;
	i = 0;
	while (tx_ready_o !== 1'b1 && i < 400) begin
		@(posedge clk_i);
		i++;
	end
	if (i == 400) close_out(1'b1);
endtask
// Inputs start on a tick edge so a dominant bit clears the rx synchronizer in time
task automatic run(input cef_row_t rw, input logic rdy);
	tk(1);
	in <= rw.in;
	clr <= 1'b1;
	@(posedge clk_i);
	clr <= 1'b0;
	tk(rw.n);
	in <= 10'h000;
	repeat (8) @(posedge clk_i);
	chk(seen, rw.ev);
	if (rdy) ready();
	chk({tec_o, rec_o}, {rw.t, rw.r});
endtask
////////////////////////////////////////////////////////////////
initial begin
	repeat (20) @(posedge clk_i);
	chk({tx_o, drive_en_o, state_o, tec_o, rec_o}, {7'h41, 16'h0000});
	nrst_i <= 1'b1;
	tk(10);
	settle();
	chk(state_o, 5'h01);
	tk(1);
	settle();
	chk(state_o, 5'h02);
	remote_i <= 1'b1;
	data_field_i <= 1'b1;
	tk(2);
	settle();
	chk(suppress_data_o, 1'b1);
	remote_i <= 1'b0;
	data_field_i <= 1'b0;
	eof_done_i <= 1'b0;
	settle();
	chk(tx_ready_o, 1'b0);
	eof_done_i <= 1'b1;
	settle();
	chk(tx_ready_o, 1'b1);
	for (k = 0; k < 7; k++) run(rows[k], 1'b1);
	// CRC flag must wait for the acknowledge delimiter
	crc_check_i <= 1'b1;
	tk(1);
	crc_check_i <= 1'b0;
	tk(2);
	chk(err_flag_o, 1'b0);
	ack_delim_i <= 1'b1;
	tk(1);
	ack_delim_i <= 1'b0;
	tk(1);
	settle();
	chk(err_flag_o, 1'b1);
	for (k = 0; tx_ready_o !== 1'b1 && k < 30; k++) tk(1);
	chk(k >= 14 && k <= 18, 1'b1);
	chk(rec_o, 8'd2);
	for (k = 15; k <= 255; k += 8) begin
		r = rows[2];
		r.ev = {k <= 127, 6'h01};
		r.t = (k > 247) ? 8'hFF : 8'(k + 8);
		r.r = 8'd2;
		run(r, k <= 247);
		if (k == 95) chk(state_o, 5'h04);
		if (k == 127) chk(state_o, 5'h08);
	end
	chk({drive_en_o, state_o}, 6'h10);
	tk(1400);
	settle();
	chk(state_o, 5'h10);
	tk(12);
	settle();
	chk({state_o, tec_o, rec_o}, {5'h02, 16'h0000});
	wake_i <= 1'b1;
	@(posedge clk_i);
	wake_i <= 1'b0;
	settle();
	chk({drive_en_o, state_o}, 6'h01);
	tk(5);
	in <= 10'h004;
	tk(1);
	in <= 10'h000;
	tk(10);
	settle();
	chk(state_o, 5'h01);
	tk(1);
	settle();
	chk(state_o, 5'h02);
	close_out(1'b0);
end
endmodule // cef_fault_state_test
`default_nettype wire
